// ### rtl/sideband_pkg.sv
// shared constants and state types of the module sideband control logic
package sideband_pkg;
	// clock and timing figures
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned RESET_MIN_NS = 10000;
	localparam int unsigned RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned INIT_TIME_US = 100;
	localparam int unsigned INIT_CYCLES = (INIT_TIME_US * 1000) / CLK_PERIOD_NS;

	// two-wire management bus device address, 8-bit write form
	localparam logic [7:0] DEVICE_ADDRESS = 8'hA0;

	// management byte map
	localparam int unsigned MEM_DEPTH_DEFAULT = 8;
	localparam int unsigned STATUS_OFFSET = 0;
	localparam int unsigned FLAG_OFFSET = 1;
	localparam int unsigned FIRST_SETTING = 2;
	localparam int unsigned STATUS_NOT_READY_BIT = 0;
	localparam int unsigned STATUS_LOW_POWER_BIT = 1;
	localparam int unsigned FLAG_RESET_DONE_BIT = 0;
	localparam logic [7:0] SETTING_RESET = 8'h00;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// two-wire bus slave states
	typedef enum logic [6:0] {
		BUS_IDLE = 7'h01,
		BUS_ADDR = 7'h02,
		BUS_ADDR_ACK = 7'h04,
		BUS_WRITE = 7'h08,
		BUS_WRITE_ACK = 7'h10,
		BUS_READ = 7'h20,
		BUS_READ_ACK = 7'h40
	} bus_state_t;

	// reset execution states
	typedef enum logic [1:0] {
		INIT_RUN = 2'h1,
		INIT_READY = 2'h2
	} init_state_t;
endpackage

// ### rtl/reset_pulse_qualifier.sv
// qualifies a low pulse on the module reset pin and marks its release
`timescale 1ns/1ps
module reset_pulse_qualifier import sideband_pkg::*; #(
	parameter int unsigned MIN_LOW_CYCLES = RESET_MIN_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic level_n,
	output logic release_pulse
);
	localparam int unsigned CW = $clog2(MIN_LOW_CYCLES + 1);

	logic [CW-1:0] low_count;
	logic [CW-1:0] next_low_count;
	logic level_prev;
	logic next_release_pulse;

	// count low cycles, saturating; flag the rising edge of a long enough pulse
	always_comb begin
		next_low_count = low_count;
		if (!level_n) begin
			if (low_count < CW'(MIN_LOW_CYCLES)) begin
				next_low_count = low_count + CW'(1);
			end
		end else begin
			next_low_count = '0;
		end
		next_release_pulse = level_n && !level_prev && (low_count >= CW'(MIN_LOW_CYCLES));
	end

	// pin idles high, so a released line starts as high
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			low_count <= '0;
			level_prev <= 1'b1;
			release_pulse <= 1'b0;
		end else begin
			low_count <= next_low_count;
			level_prev <= level_n;
			release_pulse <= next_release_pulse;
		end
	end
endmodule // reset_pulse_qualifier

// ### rtl/module_sideband_control.sv
// sideband pins, management bus slave and reset sequencing of the module
`timescale 1ns/1ps
module module_sideband_control import sideband_pkg::*; #(
	parameter int unsigned RESET_LOW_CYCLES = RESET_MIN_CYCLES,
	parameter int unsigned INIT_RUN_CYCLES = INIT_CYCLES,
	parameter int unsigned MEM_DEPTH = MEM_DEPTH_DEFAULT
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic module_select_pin_n,
	input wire logic module_reset_n,
	input wire logic low_power_request,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic module_present_n,
	output logic interrupt_out_n_out,
	output logic interrupt_out_n_oe,
	output logic low_power_state,
	output logic data_not_ready
);
	localparam int unsigned PW = $clog2(MEM_DEPTH);
	localparam int unsigned IW = $clog2(INIT_RUN_CYCLES + 1);

	bus_state_t bus_state, next_bus_state;
	logic [3:0] bit_count, next_bit_count;
	logic [7:0] shift, next_shift;
	logic [7:0] tx, next_tx;
	logic next_sda_oe;
	logic [PW-1:0] ptr, next_ptr;
	logic first_byte, next_first_byte;
	logic nack, next_nack;
	logic scl_prev, sda_prev;
	logic selected;
	logic start_seen, stop_seen;
	logic scl_rise, scl_fall;
	logic write_strobe, flag_read;
	logic [7:0] rd_byte;

	init_state_t init_state, next_init_state;
	logic [IW-1:0] init_count, next_init_count;
	logic next_data_not_ready;
	logic reset_done, next_reset_done;
	logic set_done, load_defaults;
	logic release_pulse;
	logic [7:0] settings [MEM_DEPTH-1:FIRST_SETTING];

	// reset pin qualifier
	reset_pulse_qualifier #(
		.MIN_LOW_CYCLES(RESET_LOW_CYCLES)
	) u_reset_qualifier (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.level_n(module_reset_n),
		.release_pulse(release_pulse)
	);

	// fixed pin levels: presence grounded, open-collector lines drive only low
	assign module_present_n = 1'b0;
	assign sda_out = 1'b0;
	assign interrupt_out_n_out = 1'b0;
	assign interrupt_out_n_oe = reset_done;

	// bus line events; the pad pull-up makes a floating select read high
	assign selected = !module_select_pin_n;
	assign start_seen = scl && scl_prev && sda_prev && !sda_in;
	assign stop_seen = scl && scl_prev && !sda_prev && sda_in;
	assign scl_rise = scl && !scl_prev;
	assign scl_fall = !scl && scl_prev;

	// byte seen by the host at the current pointer
	always_comb begin
		rd_byte = 8'h00;
		if (ptr == PW'(STATUS_OFFSET)) begin
			rd_byte[STATUS_NOT_READY_BIT] = data_not_ready;
			rd_byte[STATUS_LOW_POWER_BIT] = low_power_state;
		end else if (ptr == PW'(FLAG_OFFSET)) begin
			rd_byte[FLAG_RESET_DONE_BIT] = reset_done;
		end else begin
			rd_byte = settings[ptr];
		end
	end

	// two-wire management bus slave
	always_comb begin
		next_bus_state = bus_state;
		next_bit_count = bit_count;
		next_shift = shift;
		next_tx = tx;
		next_sda_oe = sda_oe;
		next_ptr = ptr;
		next_first_byte = first_byte;
		next_nack = nack;
		write_strobe = 1'b0;
		flag_read = 1'b0;
		if (!selected) begin
			next_bus_state = BUS_IDLE;
			next_sda_oe = 1'b0;
		end else if (start_seen) begin
			next_bus_state = BUS_ADDR;
			next_bit_count = 4'h0;
			next_sda_oe = 1'b0;
		end else if (stop_seen) begin
			next_bus_state = BUS_IDLE;
			next_sda_oe = 1'b0;
		end else if (scl_rise) begin
			case (bus_state)
				BUS_ADDR, BUS_WRITE: begin
					next_shift = {shift[6:0], sda_in};
					next_bit_count = bit_count + 4'h1;
				end
				BUS_READ: next_bit_count = bit_count + 4'h1;
				BUS_READ_ACK: next_nack = sda_in;
				default: ;
			endcase
		end else if (scl_fall) begin
			case (bus_state)
				BUS_ADDR: begin
					if (bit_count == BITS_PER_BYTE) begin
						if (shift[7:1] == DEVICE_ADDRESS[7:1]) begin
							next_bus_state = BUS_ADDR_ACK;
							next_sda_oe = 1'b1;
						end else begin
							next_bus_state = BUS_IDLE;
						end
					end
				end
				BUS_ADDR_ACK: begin
					next_bit_count = 4'h0;
					if (shift[0]) begin
						next_bus_state = BUS_READ;
						next_tx = rd_byte;
						next_sda_oe = !rd_byte[7];
						next_ptr = ptr + PW'(1);
						flag_read = (ptr == PW'(FLAG_OFFSET));
					end else begin
						next_bus_state = BUS_WRITE;
						next_first_byte = 1'b1;
						next_sda_oe = 1'b0;
					end
				end
				BUS_WRITE: begin
					if (bit_count == BITS_PER_BYTE) begin
						next_bus_state = BUS_WRITE_ACK;
						next_sda_oe = 1'b1;
						if (first_byte) begin
							next_ptr = shift[PW-1:0];
							next_first_byte = 1'b0;
						end else begin
							write_strobe = 1'b1;
							next_ptr = ptr + PW'(1);
						end
					end
				end
				BUS_WRITE_ACK: begin
					next_bus_state = BUS_WRITE;
					next_sda_oe = 1'b0;
					next_bit_count = 4'h0;
				end
				BUS_READ: begin
					if (bit_count == BITS_PER_BYTE) begin
						next_bus_state = BUS_READ_ACK;
						next_sda_oe = 1'b0;
					end else begin
						next_tx = {tx[6:0], 1'b0};
						next_sda_oe = !tx[6];
					end
				end
				BUS_READ_ACK: begin
					next_bit_count = 4'h0;
					if (nack) begin
						next_bus_state = BUS_IDLE;
					end else begin
						next_bus_state = BUS_READ;
						next_tx = rd_byte;
						next_sda_oe = !rd_byte[7];
						next_ptr = ptr + PW'(1);
						flag_read = (ptr == PW'(FLAG_OFFSET));
					end
				end
				default: begin
					next_bus_state = BUS_IDLE;
					next_sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			bus_state <= BUS_IDLE;
			bit_count <= 4'h0;
			shift <= 8'h00;
			tx <= 8'h00;
			sda_oe <= 1'b0;
			ptr <= '0;
			first_byte <= 1'b0;
			nack <= 1'b0;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			bus_state <= next_bus_state;
			bit_count <= next_bit_count;
			shift <= next_shift;
			tx <= next_tx;
			sda_oe <= next_sda_oe;
			ptr <= next_ptr;
			first_byte <= next_first_byte;
			nack <= next_nack;
			scl_prev <= scl;
			sda_prev <= sda_in;
		end
	end

	// reset execution timer; power-up enters it straight from rstn
	always_comb begin
		next_init_state = init_state;
		next_init_count = init_count;
		next_data_not_ready = data_not_ready;
		set_done = 1'b0;
		load_defaults = 1'b0;
		case (init_state)
			INIT_RUN: begin
				if (init_count == IW'(INIT_RUN_CYCLES - 1)) begin
					next_init_state = INIT_READY;
					next_data_not_ready = 1'b0;
					set_done = 1'b1;
				end else begin
					next_init_count = init_count + IW'(1);
				end
			end
			INIT_READY: ;
			default: next_init_state = INIT_RUN;
		endcase
		if (release_pulse) begin
			next_init_state = INIT_RUN;
			next_init_count = '0;
			next_data_not_ready = 1'b1;
			load_defaults = 1'b1;
			set_done = 1'b0;
		end
		// a completion landing on the clearing read stays posted; a pin reset withdraws it
		next_reset_done = set_done || (reset_done && !flag_read && !release_pulse);
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			init_state <= INIT_RUN;
			init_count <= '0;
			data_not_ready <= 1'b1;
			reset_done <= 1'b0;
			low_power_state <= 1'b0;
		end else begin
			init_state <= next_init_state;
			init_count <= next_init_count;
			data_not_ready <= next_data_not_ready;
			reset_done <= next_reset_done;
			low_power_state <= low_power_request;
		end
	end

	// user-writable settings bytes
	genvar gi;
	generate
		for (gi = FIRST_SETTING; gi < MEM_DEPTH; gi++) begin : g_setting
			logic [7:0] next_setting;
			always_comb begin
				next_setting = settings[gi];
				if (load_defaults) begin
					next_setting = SETTING_RESET;
				end else if (write_strobe && (ptr == PW'(gi))) begin
					next_setting = shift;
				end
			end
			always_ff @(posedge sys_clk) begin
				if (!rstn) begin
					settings[gi] <= SETTING_RESET;
				end else begin
					settings[gi] <= next_setting;
				end
			end
		end
	endgenerate
endmodule // module_sideband_control

// ### verif/sideband_chk.sv
// assertions on the sideband pins and reset sequencing of the module
`timescale 1ns/1ps
module sideband_chk import sideband_pkg::*; #(
	parameter int unsigned RESET_LOW_CYCLES = RESET_MIN_CYCLES,
	parameter int unsigned INIT_RUN_CYCLES = INIT_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic module_select_pin_n,
	input wire logic module_reset_n,
	input wire logic low_power_request,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic module_present_n,
	input wire logic interrupt_out_n_out,
	input wire logic interrupt_out_n_oe,
	input wire logic low_power_state,
	input wire logic data_not_ready
);
	localparam int DONE_LO = INIT_RUN_CYCLES - 2;
	localparam int DONE_HI = INIT_RUN_CYCLES + 4;
	logic [15:0] low_run;
	logic [15:0] next_low_run;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// length of the current low run on the reset pin, saturating
	always_comb begin
		next_low_run = module_reset_n ? 16'h0000 : low_run + ((&low_run) ? 16'h0000 : 16'h0001);
	end
	always_ff @(posedge sys_clk) begin
		low_run <= rstn ? next_low_run : 16'h0000;
	end
	// fixed pin levels, the select gate and the low power state
	present_grounded_a: assert property (module_present_n == 1'b0) else $error("presence not low");
	int_open_drain_a: assert property (interrupt_out_n_out == 1'b0) else $error("interrupt driven high");
	sda_open_drain_a: assert property (sda_out == 1'b0) else $error("data driven high");
	deselect_quiet_a: assert property ($past(module_select_pin_n) |-> !sda_oe) else $error("data pulled when idle");
	low_power_a: assert property ($past(rstn) |-> low_power_state == $past(low_power_request))
		else $error("low power state wrong");
	// power-up and pin reset sequencing
	powerup_pending_a: assert property ($rose(rstn) |-> data_not_ready && !interrupt_out_n_oe)
		else $error("no pending flag");
	powerup_done_a: assert property ($rose(rstn) |-> ##[DONE_LO:DONE_HI] (!data_not_ready && interrupt_out_n_oe))
		else $error("no power-up completion");
	done_raises_int_a: assert property ($fell(data_not_ready) |-> interrupt_out_n_oe) else $error("done, no interrupt");
	hold_low_idle_a: assert property (!module_reset_n |=> !$rose(data_not_ready)) else $error("reset began while low");
	pin_reset_a: assert property (($rose(module_reset_n) && low_run >= RESET_LOW_CYCLES) |-> ##[1:3] $rose(data_not_ready))
		else $error("long pulse ignored");
	short_pulse_a: assert property (($rose(module_reset_n) && low_run < RESET_LOW_CYCLES && !data_not_ready)
		|=> !data_not_ready [*4]) else $error("short pulse taken");
	exec_time_a: assert property ($rose(data_not_ready) |-> ##[DONE_LO:DONE_HI] $fell(data_not_ready))
		else $error("reset execution time wrong");
	cover property ($fell(data_not_ready));
	cover property ($rose(sda_oe));
	cover property ($rose(low_power_state));
	cover property ($fell(interrupt_out_n_oe));
endmodule // sideband_chk

bind module_sideband_control sideband_chk #(.RESET_LOW_CYCLES(RESET_LOW_CYCLES), .INIT_RUN_CYCLES(INIT_RUN_CYCLES))
	sideband_chk_i (.sys_clk(sys_clk), .rstn(rstn), .module_select_pin_n(module_select_pin_n),
	.module_reset_n(module_reset_n), .low_power_request(low_power_request), .sda_out(sda_out), .sda_oe(sda_oe),
	.module_present_n(module_present_n), .interrupt_out_n_out(interrupt_out_n_out),
	.interrupt_out_n_oe(interrupt_out_n_oe), .low_power_state(low_power_state), .data_not_ready(data_not_ready));

// ### verif/host_model.sv
// two-wire bus master standing in for the host board controller
`timescale 1ns/1ps
module host_model import sideband_pkg::*; (
	input wire logic sys_clk,
	input wire logic sda_wire,
	output logic scl,
	output logic sda_low
);
	int half_len = 4;
	// idle bus: clock high, data released to its pull-up
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic half();
		repeat (half_len) @(negedge sys_clk);
	endtask
	// one bit slot, data set while the clock is low; returns the line seen at the clock high
	task automatic slot(input logic b, output logic s);
		sda_low = !b;
		half();
		scl = 1'b1;
		half();
		s = sda_wire;
		scl = 1'b0;
		half();
	endtask
	// start or repeated start: data falls while the clock is high
	task automatic start();
		sda_low = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda_low = 1'b1;
		half();
		scl = 1'b0;
		half();
	endtask
	task automatic stop();
		sda_low = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda_low = 1'b0;
		half();
	endtask
	// a byte out, top bit first; ack when the device pulls data low
	task automatic put(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) slot(d[i], s);
		slot(1'b1, s);
		ack = !s;
	endtask
	// a byte in, then the host's own ack or nack
	task automatic get(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			slot(1'b1, s);
			d[i] = s;
		end
		slot(nack, s);
	endtask
	// pointer then one data byte; ok only when every byte was acked
	task automatic wr(input logic [7:0] dev, input logic [7:0] ptr, input logic [7:0] dat, output logic ok);
		logic a0, a1, a2;
		start();
		put(dev, a0);
		put(ptr, a1);
		put(dat, a2);
		stop();
		ok = a0 && a1 && a2;
	endtask
	// pointer set, repeated start, one byte read closed by a nack
	task automatic rd(input logic [7:0] ptr, output logic [7:0] d, output logic ok);
		logic a0, a1, a2;
		start();
		put(DEVICE_ADDRESS, a0);
		put(ptr, a1);
		start();
		put(DEVICE_ADDRESS | 8'h01, a2);
		get(1'b1, d);
		stop();
		ok = a0 && a1 && a2;
	endtask
endmodule // host_model

// ### verif/module_sideband_control_bench.sv
// self-checking bench for the module sideband control block
`timescale 1ns/1ps
module module_sideband_control_bench import sideband_pkg::*;;
	localparam int unsigned LOW_N = 4;
	logic sys_clk, rstn, module_select_pin_n, module_reset_n, low_power_request, scl, host_sda_low, sda_wire;
	logic sda_out, sda_oe, module_present_n, interrupt_out_n_out, interrupt_out_n_oe, low_power_state;
	logic data_not_ready, ok;
	logic [7:0] rd_byte;
	int err_count = 0;
	int checks_done = 0;
	// pulled-up data line, low when either party pulls it
	assign sda_wire = !(sda_oe || host_sda_low);
	module_sideband_control #(.RESET_LOW_CYCLES(LOW_N), .INIT_RUN_CYCLES(20), .MEM_DEPTH(8)) module_sideband_control_i (
		.sys_clk(sys_clk), .rstn(rstn), .module_select_pin_n(module_select_pin_n), .module_reset_n(module_reset_n),
		.low_power_request(low_power_request), .scl(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
		.module_present_n(module_present_n), .interrupt_out_n_out(interrupt_out_n_out),
		.interrupt_out_n_oe(interrupt_out_n_oe), .low_power_state(low_power_state), .data_not_ready(data_not_ready));
	host_model host_model_i (.sys_clk(sys_clk), .sda_wire(sda_wire), .scl(scl), .sda_low(host_sda_low));
	task automatic close_out();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic check1(input logic got, input logic exp);
		check8({7'h00, got}, {7'h00, exp});
	endtask
	task automatic rd_check(input logic [7:0] ptr, input logic [7:0] exp);
		host_model_i.rd(ptr, rd_byte, ok);
		check1(ok, 1'b1);
		check8(rd_byte, exp);
	endtask
	// waits for the end of reset execution, bounded
	task automatic wait_done();
		for (int n = 0; n < 200 && data_not_ready !== 1'b0; n++) @(negedge sys_clk);
	endtask
	task automatic pulse(input int n);
		module_reset_n = 1'b0;
		repeat (n) @(negedge sys_clk);
		module_reset_n = 1'b1;
	endtask
	// free-running clock and watchdog
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (50000) @(posedge sys_clk);
		err_count++;
		close_out();
	end
	// main sequence
	initial begin
		rstn = 1'b0;
		module_select_pin_n = 1'b1;
		module_reset_n = 1'b1;
		low_power_request = 1'b0;
		repeat (20) @(negedge sys_clk);
		rstn = 1'b1;
		@(negedge sys_clk);
		check1(data_not_ready, 1'b1);
		wait_done();
		check1(interrupt_out_n_oe, 1'b1);
		check1(module_present_n, 1'b0);
		module_select_pin_n = 1'b0;
		host_model_i.wr(DEVICE_ADDRESS, 8'h02, 8'h5A, ok);
		check1(ok, 1'b1);
		host_model_i.half_len = 7;
		rd_check(8'h02, 8'h5A);
		host_model_i.half_len = 4;
		rd_check(8'h01, 8'h01);
		check1(interrupt_out_n_oe, 1'b0);
		low_power_request = 1'b1;
		@(negedge sys_clk);
		check1(low_power_state, 1'b1);
		rd_check(8'h00, 8'h02);
		low_power_request = 1'b0;
		host_model_i.wr(8'hA2, 8'h03, 8'h33, ok);
		check1(ok, 1'b0);
		module_select_pin_n = 1'b1;
		host_model_i.wr(DEVICE_ADDRESS, 8'h03, 8'h33, ok);
		check1(ok, 1'b0);
		module_select_pin_n = 1'b0;
		rd_check(8'h03, 8'h00);
		pulse(LOW_N - 1);
		repeat (6) @(negedge sys_clk);
		check1(data_not_ready, 1'b0);
		pulse(LOW_N);
		repeat (3) @(negedge sys_clk);
		check1(data_not_ready, 1'b1);
		wait_done();
		check1(interrupt_out_n_oe, 1'b1);
		rd_check(8'h02, 8'h00);
		close_out();
	end
endmodule // module_sideband_control_bench
